//--- common/modem_ctl_pkg.sv
// Purpose: Types shared by the modem serial control block
// Assumes: Nothing beyond the register header
// Notes:   Undefined function codes are not members of the enum
package modem_ctl_pkg;

    typedef enum logic [3:0] {
        FM_FSK       = 4'h0,
        FM_FSK_LB    = 4'h1,
        FM_CALL_PROGRESS_DETECT      = 4'h2,
        FM_ANSWER    = 4'h3,
        FM_DTMF_TX   = 4'h4,
        FM_SINGLE    = 4'h5,
        FM_PD1       = 4'h6,
        FM_PD2       = 4'h7,
        FM_DTMF_RX   = 4'h8,
        FM_DTMF_LB   = 4'h9
    } func_mode_e;

    typedef enum logic [2:0] {
        LS_MID       = 3'h0,
        LS_FSK       = 3'h1,
        LS_ANSWER    = 3'h2,
        LS_DUAL      = 3'h3,
        LS_SINGLE    = 3'h4
    } line_src_e;

endpackage

//--- common/modem_ctl_regs.svh
// Purpose: Offsets, field positions and codes of the modem serial control block
// Assumes: Control word is shifted in with the function select first
// Notes:   Definitions only
`ifndef MODEM_CTL_REGS_SVH
`define MODEM_CTL_REGS_SVH

`define MC_WORD_WIDTH   16
`define MC_STAT_WIDTH   4
`define MC_FUNC_MSB     15
`define MC_FUNC_LSB     12
`define MC_LEVEL_MSB    11
`define MC_LEVEL_LSB    8
`define MC_TONE_MSB     7
`define MC_TONE_LSB     4
`define MC_MUTE_BIT     3
`define MC_CHAN_BIT     2
`define MC_DET_HI_BIT   1
`define MC_DET_LO_BIT   0
`define MC_RESET_WORD   16'h7000
`define MC_AGC_STEP_MAX 4'hA
`define MC_AGC_CLAMP    4'hB
`define MC_AGC_AUTO     4'hC
`define MC_STAT_FIRST   2'h0
`define MC_STAT_STEP    2'h1
`define MC_PIN_COUNT    4
`define MC_PIN_SCK      0
`define MC_PIN_E        1
`define MC_PIN_RW       2
`define MC_PIN_DATA     3

`endif

//--- design/modem_mode_ctl.sv
// Purpose: Serial control interface and mode control of a 300-baud FSK/DTMF modem
// Assumes: Pins i_sck, i_e, i_rw, i_data_in are asynchronous; detector inputs share i_clk
// Notes:   Analog paths are represented only by the selects and enables they need
//
// Overview of operation
// - Direction low: each rising shift clock shifts one data bit into the word
// - Direction low and strobe high: word passes through to the active settings
// - Direction high: strobe rise loads decoded tone, bit 0 driven on data pin
// - Each following shift clock rise presents next status bit, wrapping 3 to 0
// - Function select decodes ten modes, FSK through tone loopback
// - FSK: receive data out, detect low while carrier valid
// - Tone transmit: dual tone out, receiver off, receive data and detect high
// - Call progress: detect low on valid tone, receive data high, line mid-supply
// - Answer tone: 2100 Hz out, receiver off, receive data and detect high
// - FSK loopback: modulator fed to demodulator, outputs as in FSK
// - Tone receive: valid low on tone, receive data high, line mid-supply
// - Tone loopback: generator fed to receiver, valid low on recognised tone
// - Single tone: one of eight frequencies by tone code, receive data and detect high
// - Power-down 1: all off but oscillator, outputs high impedance
// - Power-down 2: all off including oscillator, outputs high impedance
// - Transmit modes: level code is attenuation in dB, 0 to 15
// - Attenuation never touches the external summing input
// - Tone receive: level 0 to 10 gain steps, 11 clamp, 12 automatic
// - Tone code picks pair in transmit and loopback, single frequency in single
// - Reset places the device in power-down 2
// - Mute bit set: tones and FSK off, line at mid-supply, summing input kept
// - FSK modes: channel bit 1 originate, 0 answer
`timescale 1ns/1ns
`include "modem_ctl_regs.svh"
module modem_mode_ctl #(
    parameter int TONE_WIDTH = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_sck,
    input  wire logic             i_e,
    input  wire logic             i_rw,
    input  wire logic             i_data_in,
    output logic                  o_data_out,
    output logic                  o_data_oe_b,
    input  wire logic             i_fsk_rx_data,
    input  wire logic             i_carrier_valid,
    input  wire logic             i_call_progress_detect_valid,
    input  wire logic             i_tone_valid,
    input  wire logic [TONE_WIDTH-1:0] i_rx_tone_code,
    output logic                  o_rxd,
    output logic                  o_rxd_oe_b,
    output logic                  o_detect_out,
    output logic                  o_detect_oe_b,
    output logic [2:0]            o_line_src,
    output logic                  o_line_oe_b,
    output logic                  o_dsi_pass,
    output logic                  o_osc_en,
    output logic                  o_osc_out_oe_b,
    output logic                  o_rx_enable,
    output logic                  o_fsk_loopback,
    output logic                  o_dtmf_loopback,
    output logic                  o_channel_orig,
    output logic [3:0]            o_tx_atten_db,
    output logic [3:0]            o_agc_step,
    output logic                  o_agc_clamp,
    output logic                  o_agc_auto,
    output logic [TONE_WIDTH-1:0] o_tone_code,
    output logic                  o_single_high_group,
    output logic [1:0]            o_detect_time_sel
);

    initial
    begin
        if (TONE_WIDTH != `MC_STAT_WIDTH)
            $error("modem_mode_ctl: TONE_WIDTH must be 4");
    end

    // Pin synchronisers; stage one feeds only stage two
    logic [`MC_PIN_COUNT-1:0] pin_s1_r;
    logic [`MC_PIN_COUNT-1:0] pin_s2_r;
    logic [`MC_PIN_COUNT-1:0] pin_s3_r;
    logic [`MC_PIN_COUNT-1:0] pin_raw;

    assign pin_raw = {i_data_in, i_rw, i_e, i_sck};

    genvar g;
    generate
        for (g = 0; g < `MC_PIN_COUNT; g++)
        begin : g_sync
            always_ff @(posedge i_clk)
            begin
                if (!i_rst_b)
                begin
                    pin_s1_r[g] <= 1'b0;
                    pin_s2_r[g] <= 1'b0;
                    pin_s3_r[g] <= 1'b0;
                end
                else
                begin
                    pin_s1_r[g] <= pin_raw[g];
                    pin_s2_r[g] <= pin_s1_r[g];
                    pin_s3_r[g] <= pin_s2_r[g];
                end
            end
        end
    endgenerate

    logic sck_rise;
    logic e_rise;
    logic e_s;
    logic rw_s;
    logic data_s;

    assign sck_rise = pin_s2_r[`MC_PIN_SCK] && !pin_s3_r[`MC_PIN_SCK];
    assign e_rise   = pin_s2_r[`MC_PIN_E] && !pin_s3_r[`MC_PIN_E];
    assign e_s      = pin_s2_r[`MC_PIN_E];
    assign rw_s     = pin_s2_r[`MC_PIN_RW];
    assign data_s   = pin_s2_r[`MC_PIN_DATA];

    // Control word shifter
    logic                      shift_en;
    logic [`MC_WORD_WIDTH-1:0] shift_word;

    assign shift_en = sck_rise && !rw_s;

    serial_shift_reg #(
        .WIDTH   (`MC_WORD_WIDTH)
    ) u_shift (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_shift (shift_en),
        .i_bit   (data_s),
        .o_word  (shift_word)
    );

    // Active settings; transparent while strobe high so a strobe held
    // during shifting would expose partial words to the mode logic
    logic [`MC_WORD_WIDTH-1:0] active_r;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            active_r <= `MC_RESET_WORD;
        else if (!rw_s && e_s)
            active_r <= shift_word;
    end

    modem_ctl_pkg::func_mode_e func;
    logic [3:0]                level;
    logic                      tx_mute;
    logic                      channel_sel;

    assign func        = modem_ctl_pkg::func_mode_e'(active_r[`MC_FUNC_MSB:`MC_FUNC_LSB]);
    assign level       = active_r[`MC_LEVEL_MSB:`MC_LEVEL_LSB];
    assign tx_mute     = active_r[`MC_MUTE_BIT];
    assign channel_sel = active_r[`MC_CHAN_BIT];

    // Status readout
    logic [TONE_WIDTH-1:0] status_r;
    logic [1:0]            rd_idx_r;
    logic [1:0]            rd_idx_next;
    logic                  data_out_r;

    assign rd_idx_next = rd_idx_r + `MC_STAT_STEP;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            status_r   <= '0;
            rd_idx_r   <= `MC_STAT_FIRST;
            data_out_r <= 1'b0;
        end
        else if (rw_s && e_rise)
        begin
            status_r   <= i_rx_tone_code;
            rd_idx_r   <= `MC_STAT_FIRST;
            data_out_r <= i_rx_tone_code[`MC_STAT_FIRST];
        end
        else if (rw_s && sck_rise)
        begin
            rd_idx_r   <= rd_idx_next;
            data_out_r <= status_r[rd_idx_next];
        end
        else if (!rw_s)
            rd_idx_r   <= `MC_STAT_FIRST;
    end

    // Mode decode
    logic                      outs_on;
    logic                      osc_nxt;
    logic                      rx_en_nxt;
    logic                      fsk_lb_nxt;
    logic                      dtmf_lb_nxt;
    logic                      tx_mode;
    logic                      rxd_nxt;
    logic                      det_nxt;
    modem_ctl_pkg::line_src_e  line_nxt;

    always_comb
    begin
        outs_on     = 1'b1;
        osc_nxt     = 1'b1;
        rx_en_nxt   = 1'b0;
        fsk_lb_nxt  = 1'b0;
        dtmf_lb_nxt = 1'b0;
        tx_mode     = 1'b0;
        rxd_nxt     = 1'b1;
        det_nxt     = 1'b1;
        line_nxt    = modem_ctl_pkg::LS_MID;
        unique case (func)
            modem_ctl_pkg::FM_FSK, modem_ctl_pkg::FM_FSK_LB:
            begin
                rx_en_nxt  = 1'b1;
                tx_mode    = 1'b1;
                fsk_lb_nxt = (func == modem_ctl_pkg::FM_FSK_LB);
                det_nxt    = !i_carrier_valid;
                rxd_nxt    = i_carrier_valid ? i_fsk_rx_data : 1'b1;
                line_nxt   = modem_ctl_pkg::LS_FSK;
            end
            modem_ctl_pkg::FM_CALL_PROGRESS_DETECT:
            begin
                rx_en_nxt  = 1'b1;
                det_nxt    = !i_call_progress_detect_valid;
            end
            modem_ctl_pkg::FM_ANSWER:
            begin
                tx_mode    = 1'b1;
                line_nxt   = modem_ctl_pkg::LS_ANSWER;
            end
            modem_ctl_pkg::FM_DTMF_TX:
            begin
                tx_mode    = 1'b1;
                line_nxt   = modem_ctl_pkg::LS_DUAL;
            end
            modem_ctl_pkg::FM_SINGLE:
            begin
                tx_mode    = 1'b1;
                line_nxt   = modem_ctl_pkg::LS_SINGLE;
            end
            modem_ctl_pkg::FM_PD1:
                outs_on    = 1'b0;
            modem_ctl_pkg::FM_PD2:
            begin
                outs_on    = 1'b0;
                osc_nxt    = 1'b0;
            end
            modem_ctl_pkg::FM_DTMF_RX:
            begin
                rx_en_nxt  = 1'b1;
                det_nxt    = !i_tone_valid;
            end
            modem_ctl_pkg::FM_DTMF_LB:
            begin
                rx_en_nxt   = 1'b1;
                tx_mode     = 1'b1;
                dtmf_lb_nxt = 1'b1;
                det_nxt     = !i_tone_valid;
                line_nxt    = modem_ctl_pkg::LS_DUAL;
            end
            default:
                outs_on    = 1'b0;
        endcase
        if (tx_mute)
            line_nxt = modem_ctl_pkg::LS_MID;
    end

    // Registered pin outputs
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_rxd          <= 1'b1;
            o_detect_out   <= 1'b1;
            o_rxd_oe_b     <= 1'b1;
            o_detect_oe_b  <= 1'b1;
            o_line_oe_b    <= 1'b1;
            o_line_src     <= modem_ctl_pkg::LS_MID;
            o_dsi_pass     <= 1'b0;
            o_osc_en       <= 1'b0;
            o_osc_out_oe_b <= 1'b1;
        end
        else
        begin
            o_rxd          <= rxd_nxt;
            o_detect_out   <= det_nxt;
            o_rxd_oe_b     <= !outs_on;
            o_detect_oe_b  <= !outs_on;
            o_line_oe_b    <= !outs_on;
            o_line_src     <= line_nxt;
            o_dsi_pass     <= outs_on;
            o_osc_en       <= osc_nxt;
            o_osc_out_oe_b <= !osc_nxt;
        end
    end

    // Analog settings
    logic dtmf_rx;

    assign dtmf_rx = (func == modem_ctl_pkg::FM_DTMF_RX);

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_rx_enable         <= 1'b0;
            o_fsk_loopback      <= 1'b0;
            o_dtmf_loopback     <= 1'b0;
            o_channel_orig      <= 1'b0;
            o_tx_atten_db       <= '0;
            o_agc_step          <= '0;
            o_agc_clamp         <= 1'b0;
            o_agc_auto          <= 1'b0;
            o_tone_code         <= '0;
            o_single_high_group <= 1'b0;
            o_detect_time_sel   <= '0;
        end
        else
        begin
            o_rx_enable         <= rx_en_nxt && outs_on;
            o_fsk_loopback      <= fsk_lb_nxt;
            o_dtmf_loopback     <= dtmf_lb_nxt;
            // Keyed on the mode, not the line source, so mute keeps the channel
            o_channel_orig      <= (func == modem_ctl_pkg::FM_FSK || fsk_lb_nxt)
                                   && channel_sel;
            o_tx_atten_db       <= tx_mode ? level : '0;
            o_agc_step          <= (dtmf_rx && level <= `MC_AGC_STEP_MAX) ? level : '0;
            o_agc_clamp         <= dtmf_rx && (level == `MC_AGC_CLAMP);
            o_agc_auto          <= dtmf_rx && (level == `MC_AGC_AUTO);
            o_tone_code         <= active_r[`MC_TONE_MSB:`MC_TONE_LSB];
            o_single_high_group <= active_r[`MC_TONE_MSB];
            o_detect_time_sel   <= {active_r[`MC_DET_HI_BIT], active_r[`MC_DET_LO_BIT]};
        end
    end

    // Data pin driven only during readout with the device awake
    assign o_data_out  = data_out_r;
    assign o_data_oe_b = !(rw_s && o_dsi_pass);

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence seq_status_load;
        rw_s && e_rise;
    endsequence

    sequence seq_rotate_step;
        rw_s && sck_rise && !e_rise;
    endsequence

    chk_shift_capture: assert property (
        shift_en |=> shift_word[0] == $past(data_s)
                  && shift_word[`MC_WORD_WIDTH-1:1] == $past(shift_word[`MC_WORD_WIDTH-2:0]))
        else $error("control word did not shift");

    chk_transfer_load: assert property (
        (!rw_s && e_s) |=> active_r == $past(shift_word))
        else $error("strobe did not pass word to mode logic");

    chk_isolated_word: assert property (
        !e_s |=> $stable(active_r))
        else $error("settings changed with strobe low");

    chk_status_load: assert property (
        seq_status_load |=> status_r == $past(i_rx_tone_code)
                        && o_data_out == $past(i_rx_tone_code[0]))
        else $error("status not loaded on strobe");

    chk_status_rotate: assert property (
        seq_rotate_step
        |=> rd_idx_r == 2'($past(rd_idx_r) + `MC_STAT_STEP)
            && o_data_out == status_r[rd_idx_r])
        else $error("status bit order wrong");

    chk_fsk_detect: assert property (
        (func == modem_ctl_pkg::FM_FSK) ##1 (func == modem_ctl_pkg::FM_FSK)
        |-> o_detect_out == !$past(i_carrier_valid))
        else $error("carrier detect output wrong in FSK");

    chk_tx_hold_high: assert property (
        (func inside {modem_ctl_pkg::FM_DTMF_TX, modem_ctl_pkg::FM_ANSWER,
                      modem_ctl_pkg::FM_SINGLE}) |=> o_rxd && o_detect_out && !o_rx_enable)
        else $error("transmit mode did not hold outputs high");

    chk_power_down_hiz: assert property (
        !outs_on |=> o_rxd_oe_b && o_detect_oe_b && o_line_oe_b && o_data_oe_b
                     && (o_osc_en == $past(osc_nxt)))
        else $error("power-down outputs not released");

    chk_mute_mid: assert property (
        tx_mute |=> o_line_src == modem_ctl_pkg::LS_MID)
        else $error("mute did not park line outputs");

    chk_atten_value: assert property (
        tx_mode |=> o_tx_atten_db == $past(level) && !o_agc_auto)
        else $error("attenuation not taken from level code");

    chk_reset_pd2: assert property (
        disable iff (1'b0) !i_rst_b |=> func == modem_ctl_pkg::FM_PD2)
        else $error("reset did not enter power-down 2");

endmodule // modem_mode_ctl

//--- design/serial_shift_reg.sv
// Purpose: Serial-in parallel-out register for the control word
// Assumes: i_shift is a one-cycle pulse on the block clock
// Notes:   First bit in ends up in the MSB after WIDTH shifts
`timescale 1ns/1ns
module serial_shift_reg #(
    parameter int WIDTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_shift,
    input  wire logic             i_bit,
    output logic [WIDTH-1:0]      o_word
);

    initial
    begin
        if (WIDTH < 2)
            $error("serial_shift_reg: WIDTH must be at least 2");
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            o_word <= '0;
        else if (i_shift)
            o_word <= {o_word[WIDTH-2:0], i_bit};
    end

endmodule // serial_shift_reg

//--- verification/host_ctl_model.sv
// Purpose: Host CPU model driving the serial control pins of the modem block
// Assumes: Pins change only just after i_clk rising edges; shift clock near 125 ns
// Notes:   A released data line toggles every cycle, so a stale bit never reads as good
`timescale 1ns/1ns
module host_ctl_model (
    input  wire logic i_clk,
    output logic      o_sck,
    output logic      o_e,
    output logic      o_rw,
    output logic      o_data
);
    initial
    begin
        o_sck  = 1'b0;
        o_e    = 1'b0;
        o_rw   = 1'b0;
        o_data = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // Function select goes out first, detect time last
    task automatic write_word(input logic [15:0] w, input logic strobe);
        o_rw <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            o_data <= w[i];
            hold(15);
            o_sck <= 1'b1;
            hold(16);
            o_sck <= 1'b0;
        end
        hold(15);
        if (strobe)
        begin
            o_e <= 1'b1; // Raised only once shifting is over
            hold(16);
            o_e <= 1'b0;
            hold(15);
        end
    endtask

    task automatic read_start();
        o_rw <= 1'b1;
        hold(15);
        o_e <= 1'b1;
        hold(16);
        o_e <= 1'b0;
        hold(15);
    endtask

    task automatic sck_pulse();
        o_sck <= 1'b1;
        hold(16);
        o_sck <= 1'b0;
        hold(15);
    endtask

    task automatic read_end();
        o_rw <= 1'b0;
        hold(8);
    endtask

    // Host has let go of the pin while reading
    always @(posedge i_clk)
        if (o_rw)
            o_data <= ~o_data;
endmodule // host_ctl_model

//--- verification/testbench.sv
// Purpose: Self-checking bench for the modem serial mode control block
// Assumes: Detector inputs share the block clock
// Notes:   Power-down rows check only enables, pin levels there are not driven
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic [15:0] word;
        logic [3:0]  det;
        logic [27:0] exp;
        logic [27:0] mask;
    } row_s;

    logic        clk = 1'b0;
    logic        rst_b;
    logic        sck, e, rw, host_data, data_pin, data_out, data_oe_b;
    logic        fsk_rx, carrier, call_progress_detect, tone_valid;
    logic [3:0]  rx_code;
    logic        rxd, rxd_oe_b, det_out, det_oe_b, line_oe_b, dsi, osc_en, osc_oe_b;
    logic        rx_en, fsk_lb, dtmf_lb, chan, single_hi, clamp, agc_auto;
    logic [2:0]  line_src;
    logic [3:0]  atten, agc_step, tone;
    logic [1:0]  det_time;
    int          err_count = 0;
    int          samples_checked = 0;
    row_s        rows [13];

    always #2 clk = ~clk;

    assign data_pin = (data_oe_b === 1'b0) ? data_out : host_data;

    host_ctl_model host_ctl_model_i (.i_clk(clk), .o_sck(sck), .o_e(e), .o_rw(rw),
        .o_data(host_data));

    modem_mode_ctl modem_mode_ctl_i (.i_clk(clk), .i_rst_b(rst_b), .i_sck(sck), .i_e(e),
        .i_rw(rw), .i_data_in(data_pin), .o_data_out(data_out), .o_data_oe_b(data_oe_b),
        .i_fsk_rx_data(fsk_rx), .i_carrier_valid(carrier), .i_call_progress_detect_valid(call_progress_detect),
        .i_tone_valid(tone_valid), .i_rx_tone_code(rx_code), .o_rxd(rxd),
        .o_rxd_oe_b(rxd_oe_b), .o_detect_out(det_out), .o_detect_oe_b(det_oe_b),
        .o_line_src(line_src), .o_line_oe_b(line_oe_b), .o_dsi_pass(dsi),
        .o_osc_en(osc_en), .o_osc_out_oe_b(osc_oe_b), .o_rx_enable(rx_en),
        .o_fsk_loopback(fsk_lb), .o_dtmf_loopback(dtmf_lb), .o_channel_orig(chan),
        .o_tx_atten_db(atten), .o_agc_step(agc_step), .o_agc_clamp(clamp),
        .o_agc_auto(agc_auto), .o_tone_code(tone), .o_single_high_group(single_hi),
        .o_detect_time_sel(det_time));

    function automatic logic [27:0] obs();
        return {rxd_oe_b, det_oe_b, osc_oe_b, dsi, line_oe_b, osc_en, line_src, rxd,
                det_out, rx_en, fsk_lb, dtmf_lb, chan, single_hi, atten, agc_step,
                clamp, agc_auto, det_time};
    endfunction

    task automatic check_vec(input logic [27:0] got, input logic [27:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checked=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard: the sequence needs far fewer cycles than this
    initial
    begin
        repeat (100000) @(posedge clk);
        err_count++;
        conclude();
    end

    initial
    begin
        rows[0]  = '{16'h053E, 4'h4, 28'h1412502, 28'hFFFEFFF};
        rows[1]  = '{16'h1F01, 4'h8, 28'h14F8F01, 28'hFFFEFFF};
        rows[2]  = '{16'h2700, 4'h2, 28'h1450000, 28'hFFFEFFF};
        rows[3]  = '{16'h3A00, 4'hF, 28'h1560A00, 28'hFFFEFFF};
        rows[4]  = '{16'h40D4, 4'hF, 28'h15E0000, 28'hFFFEFFF};
        rows[5]  = '{16'h5390, 4'hF, 28'h1661300, 28'hFFFFFFF};
        rows[6]  = '{16'h8403, 4'h1, 28'h1450043, 28'hFFFEFFF};
        rows[7]  = '{16'h8B00, 4'h0, 28'h1470008, 28'hFFFEFFF};
        rows[8]  = '{16'h8C00, 4'h1, 28'h1450004, 28'hFFFEFFF};
        rows[9]  = '{16'h9250, 4'h1, 28'h15D4200, 28'hFFFEFFF};
        rows[10] = '{16'h6000, 4'hF, 28'hCC00000, 28'hFC00000};
        rows[11] = '{16'hE000, 4'hF, 28'hCC00000, 28'hFC00000};
        rows[12] = '{16'h7000, 4'hF, 28'hE800000, 28'hFC00000};
        rst_b      = 1'b0;
        fsk_rx     = 1'b0;
        carrier    = 1'b0;
        call_progress_detect       = 1'b0;
        tone_valid = 1'b0;
        rx_code    = 4'h0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        check_vec(obs() & 28'hFC00000, 28'hE800000);
        check_vec({27'h0, data_oe_b}, 28'h1);
        // Word shifted in but never strobed must not reach the settings
        host_ctl_model_i.write_word(16'h0536, 1'b0);
        repeat (8) @(posedge clk);
        check_vec(obs() & 28'hFC00000, 28'hE800000);
        for (int k = 0; k < 13; k++)
        begin
            {fsk_rx, carrier, call_progress_detect, tone_valid} <= rows[k].det;
            host_ctl_model_i.write_word(rows[k].word, 1'b1);
            repeat (8) @(posedge clk);
            check_vec(obs() & rows[k].mask, rows[k].exp & rows[k].mask);
            if (rows[k].mask[0])
                check_vec({24'h0, tone}, {24'h0, rows[k].word[7:4]});
        end
        // Read back 1011 in tone receive mode, wrapping past bit 3
        host_ctl_model_i.write_word(16'h8C00, 1'b1);
        rx_code <= 4'hB;
        host_ctl_model_i.read_start();
        check_vec({27'h0, data_oe_b}, 28'h0);
        check_vec({27'h0, data_out}, 28'h1);
        for (int i = 1; i < 6; i++)
        begin
            host_ctl_model_i.sck_pulse();
            check_vec({27'h0, data_out}, {24'h0, 4'hB >> (i % 4)} & 28'h1);
        end
        host_ctl_model_i.read_end();
        // Data pin stays released while powered down, even when reading
        host_ctl_model_i.write_word(16'h6000, 1'b1);
        host_ctl_model_i.read_start();
        check_vec({27'h0, data_oe_b}, 28'h1);
        host_ctl_model_i.read_end();
        // Mid-run reset must fall back to power-down 2 from an awake oscillator
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        check_vec(obs() & 28'hFC00000, 28'hE800000);
        check_vec({27'h0, data_oe_b}, 28'h1);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        check_vec(obs() & 28'hFC00000, 28'hE800000);
        conclude();
    end
endmodule // testbench
